//--- hw/pgc_pin_group_io_controller.sv
// Eight-pin group controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module pgc_pin_group_io_controller #(
  parameter int        N_PINS     = 8,
  parameter bit [7:0]  FULL_ASYNC = 8'h04
) (
  input  wire logic               i_sys_clk,        // Main clock 100 MHz
  input  wire logic               i_reset_n,        // Synchronous reset, active low
  input  wire logic [7:0]         i_s_axi_awaddr,   // Write address
  input  wire logic               i_s_axi_awvalid,  // Write address valid
  output logic                    o_s_axi_awready,  // Write address ready
  input  wire logic [31:0]        i_s_axi_wdata,    // Write data
  input  wire logic [3:0]         i_s_axi_wstrb,    // Write byte strobes
  input  wire logic               i_s_axi_wvalid,   // Write data valid
  output logic                    o_s_axi_wready,   // Write data ready
  output logic [1:0]              o_s_axi_bresp,    // Write response
  output logic                    o_s_axi_bvalid,   // Write response valid
  input  wire logic               i_s_axi_bready,   // Write response ready
  input  wire logic [7:0]         i_s_axi_araddr,   // Read address
  input  wire logic               i_s_axi_arvalid,  // Read address valid
  output logic                    o_s_axi_arready,  // Read address ready
  output logic [31:0]             o_s_axi_rdata,    // Read data
  output logic [1:0]              o_s_axi_rresp,    // Read response
  output logic                    o_s_axi_rvalid,   // Read data valid
  input  wire logic               i_s_axi_rready,   // Read data ready
  input  wire logic [N_PINS-1:0]  i_pad_in,         // Pad input levels
  input  wire logic               i_global_int_en,  // Global interrupt enable
  input  wire logic               i_debug_mode,     // Debug mode indicator, ignored
  input  wire logic               i_clock_stopped,  // Main clock stopped in sleep
  output logic [N_PINS-1:0]       o_pad_out,        // Pad output level
  output logic [N_PINS-1:0]       o_pad_oe,         // Pad output enable
  output logic [N_PINS-1:0]       o_pad_pullup,     // Weak pull-up enable
  output logic [N_PINS-1:0]       o_pad_in_en,      // Input buffer enable
  output logic [N_PINS-1:0]       o_pin_event_line, // Internal pin signal after polarity
  output logic                    o_irq,            // Group interrupt request
  output logic                    o_wake            // Wake request
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0]            drive_enable_mask;
  logic [7:0]            pad_level_latch;
  logic [7:0]            pin_event_flags;
  pgc_pkg::pgc_pad_config_s pad_config [N_PINS];
  logic [N_PINS-1:0]     sync_a;
  logic [N_PINS-1:0]     sync_b;
  logic [N_PINS-1:0]     prev_line;
  logic [1:0]            dead_cnt [N_PINS];
  logic [N_PINS-1:0]     hit;
  logic [N_PINS-1:0]     sense_on;
  logic [N_PINS-1:0]     flip;
  logic [N_PINS-1:0]     line_now;
  logic [N_PINS-1:0]     wake_req;
  logic [7:0]            sampled_level;

  logic                  aw_held;
  logic                  w_held;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_go;
  logic                  wr_b0;
  logic [7:0]            wr_byte;
  logic [7:0]            rd_byte;
  logic                  rd_ok;
  logic [7:0]            rd_idx;
  logic                  wr_ok;

  // ****************************************
  // Write channel capture
  // ****************************************
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_held && !o_s_axi_bvalid;
  assign wr_go   = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_b0   = wr_go && w_strb[0];
  assign wr_byte = w_data[7:0];

  // Hold address and data until both have arrived
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= {2'b00, i_s_axi_awaddr[7:2]};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Address decode for writes
  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr > pgc_pkg::PIN_EVENT_FLAGS && aw_addr < pgc_pkg::PAD_CONFIG_PIN0)
      wr_ok = 1'b0;
    if (aw_addr >= pgc_pkg::PAD_CONFIG_PIN0 + 8'(N_PINS) && aw_addr < pgc_pkg::ALIAS_BASE)
      wr_ok = 1'b0;
    if (aw_addr > pgc_pkg::ALIAS_EVENT_FLAGS)
      wr_ok = 1'b0;
  end

  // Write response
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Drive enable mask and level latch
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      drive_enable_mask <= pgc_pkg::RESET_BYTE;
    end else if (wr_b0) begin
      unique case (aw_addr)
        pgc_pkg::DRIVE_ENABLE_MASK,
        pgc_pkg::ALIAS_DRIVE_ENABLE:         drive_enable_mask <= wr_byte;
        pgc_pkg::DRIVE_ENABLE_SET_STROBE:    drive_enable_mask <= drive_enable_mask | wr_byte;
        pgc_pkg::DRIVE_ENABLE_CLEAR_STROBE:  drive_enable_mask <= drive_enable_mask & ~wr_byte;
        pgc_pkg::DRIVE_ENABLE_TOGGLE_STROBE: drive_enable_mask <= drive_enable_mask ^ wr_byte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pad_level_latch <= pgc_pkg::RESET_BYTE;
    end else if (wr_b0) begin
      unique case (aw_addr)
        pgc_pkg::PAD_LEVEL_LATCH,
        pgc_pkg::ALIAS_LEVEL_LATCH:         pad_level_latch <= wr_byte;
        pgc_pkg::LEVEL_LATCH_SET_STROBE:    pad_level_latch <= pad_level_latch | wr_byte;
        pgc_pkg::LEVEL_LATCH_CLEAR_STROBE:  pad_level_latch <= pad_level_latch & ~wr_byte;
        pgc_pkg::LEVEL_LATCH_TOGGLE_STROBE,
        pgc_pkg::SAMPLED_LEVEL,
        pgc_pkg::ALIAS_SAMPLED_LEVEL:       pad_level_latch <= pad_level_latch ^ wr_byte;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Per-pin configuration, sensing and flags
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N_PINS; g++) begin : gen_pin
      logic [2:0] sel;
      logic       sensed;
      assign sel         = pad_config[g].sense_select;
      assign flip[g]     = pad_config[g].polarity_flip;
      assign sense_on[g] = (sel != pgc_pkg::SENSE_OFF);
      assign sensed      = sync_b[g] ^ flip[g];
      assign line_now[g] = sensed;

      // Config byte at 0x10 plus pin index
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n)
          pad_config[g] <= pgc_pkg::pgc_pad_config_s'(pgc_pkg::RESET_BYTE);
        else if (wr_b0 && aw_addr == pgc_pkg::PAD_CONFIG_PIN0 + 8'(g))
          pad_config[g] <= pgc_pkg::pgc_pad_config_s'(wr_byte & pgc_pkg::PAD_CONFIG_MASK);
      end

      // Two-stage synchronizer, frozen while sensing is off
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else if (sense_on[g]) begin
          sync_a[g] <= i_pad_in[g];
          sync_b[g] <= sync_a[g];
        end
      end

      // Previous internal level; stale across sense off so pending edges survive
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n)
          prev_line[g] <= 1'b0;
        else if (sense_on[g])
          prev_line[g] <= sensed;
      end

      // Condition decode from sense select
      always_comb begin
        hit[g] = 1'b0;
        unique case (sel)
          pgc_pkg::SENSE_DUAL_EDGE: hit[g] = sensed ^ prev_line[g];
          pgc_pkg::SENSE_RISING:    hit[g] = sensed & ~prev_line[g];
          pgc_pkg::SENSE_FALLING:   hit[g] = ~sensed & prev_line[g];
          pgc_pkg::SENSE_LOW_LEVEL: hit[g] = ~sensed;
          default:                  hit[g] = 1'b0;
        endcase
      end

      // Dead time after each flag, none on full async pins
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n)
          dead_cnt[g] <= 2'h0;
        else if (hit[g] && dead_cnt[g] == 2'h0 && !FULL_ASYNC[g])
          dead_cnt[g] <= pgc_pkg::DEAD_TIME_CYCLES;
        else if (dead_cnt[g] != 2'h0)
          dead_cnt[g] <= dead_cnt[g] - 2'h1;
      end

      // Event flag: set wins over write-one clear
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n)
          pin_event_flags[g] <= 1'b0;
        else if (sense_on[g] && hit[g] && dead_cnt[g] == 2'h0)
          pin_event_flags[g] <= 1'b1;
        else if (wr_b0 && wr_byte[g] &&
                 (aw_addr == pgc_pkg::PIN_EVENT_FLAGS || aw_addr == pgc_pkg::ALIAS_EVENT_FLAGS))
          pin_event_flags[g] <= 1'b0;
      end

      // Wake: any sense on full async pins or while the clock runs, dual edge or low level otherwise
      assign wake_req[g] = sense_on[g] && (i_pad_in[g] ^ flip[g]) !=
                           prev_line[g] && (FULL_ASYNC[g] || !i_clock_stopped ||
                           sel == pgc_pkg::SENSE_DUAL_EDGE || sel == pgc_pkg::SENSE_LOW_LEVEL);

      assign o_pad_out[g]    = pad_level_latch[g] ^ flip[g];
      assign o_pad_pullup[g] = pad_config[g].weak_high_resistor_on;
      assign o_pad_in_en[g]  = sense_on[g];
    end
  endgenerate

  // Bits above the pin count read as zero
  assign sampled_level = 8'(line_now);
  assign o_pad_oe      = drive_enable_mask[N_PINS-1:0];
  assign o_pin_event_line = line_now;
  assign o_irq  = (|pin_event_flags) && i_global_int_en;
  assign o_wake = |wake_req;

  // ****************************************
  // Read channel
  // ****************************************
  assign o_s_axi_arready = !o_s_axi_rvalid;

  // Read decode: the word address is the register index, data in byte lane 0
  assign rd_idx = {2'b00, i_s_axi_araddr[7:2]};

  // Function call inside always_comb keeps register reads in the sensitivity
  always_comb begin
    rd_byte = byte_at(rd_idx);
    rd_ok   = 1'b1;
    if (rd_idx > pgc_pkg::PIN_EVENT_FLAGS && rd_idx < pgc_pkg::PAD_CONFIG_PIN0)
      rd_ok = 1'b0;
    if (rd_idx >= pgc_pkg::PAD_CONFIG_PIN0 + 8'(N_PINS) && rd_idx < pgc_pkg::ALIAS_BASE)
      rd_ok = 1'b0;
    if (rd_idx > pgc_pkg::ALIAS_EVENT_FLAGS)
      rd_ok = 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= 2'b00;
    end else if (o_s_axi_arready && i_s_axi_arvalid) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= {24'h000000, rd_byte};
      o_s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  function automatic logic [7:0] byte_at(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a <= pgc_pkg::DRIVE_ENABLE_TOGGLE_STROBE)
      v = drive_enable_mask;
    else if (a <= pgc_pkg::LEVEL_LATCH_TOGGLE_STROBE)
      v = pad_level_latch;
    else if (a == pgc_pkg::SAMPLED_LEVEL || a == pgc_pkg::ALIAS_SAMPLED_LEVEL)
      v = sampled_level;
    else if (a == pgc_pkg::PIN_EVENT_FLAGS || a == pgc_pkg::ALIAS_EVENT_FLAGS)
      v = pin_event_flags;
    else if (a == pgc_pkg::ALIAS_DRIVE_ENABLE)
      v = drive_enable_mask;
    else if (a == pgc_pkg::ALIAS_LEVEL_LATCH)
      v = pad_level_latch;
    else if (a >= pgc_pkg::PAD_CONFIG_PIN0 && a < pgc_pkg::PAD_CONFIG_PIN0 + 8'(N_PINS))
      v = pad_config[3'(a - pgc_pkg::PAD_CONFIG_PIN0)];
    return v;
  endfunction

endmodule
`default_nettype wire

//--- hw/pgc_pkg.sv
// Package holding register map, field layout and types of the pin group controller
// What this block does
// - Drive enable mask bit one makes output
// - Drive enable set strobe sets only bit
// - Drive enable clear strobe clears only bit
// - Drive enable toggle strobe inverts bit
// - Level latch set strobe sets bit
// - Level latch clear strobe clears bit
// - Toggle strobe or sampled write inverts latch
// - Synchronizer frozen while sense is off
// - Pin level readable in either direction
// - Reset leaves drivers off, inputs on
// - Pin config byte at 0x10 plus n
// - Alias mirrors and writes like originals
// - Polarity flip inverts output and input
// - Polarity change makes a real edge
// - Resistor bit enables weak pull-up
// - Sense select chooses the flag condition
// - Wake on any sense, or limited set
// - Flip with sense change may be missed
// - Pending event may flag on re-enable
// - Sense change may drop pending event
// - Met condition sets flag, request holds
// - Request gated by global interrupt enable
// - Debug mode changes nothing
// - Direction strobes read back the mask
// - Pulse needs a clock, three-cycle gap except on full async pins
package pgc_pkg;

  // ****************************************
  // Register indices; the bus byte address is four times the index
  // ****************************************
  localparam logic [7:0] DRIVE_ENABLE_MASK          = 8'h00;
  localparam logic [7:0] DRIVE_ENABLE_SET_STROBE    = 8'h01;
  localparam logic [7:0] DRIVE_ENABLE_CLEAR_STROBE  = 8'h02;
  localparam logic [7:0] DRIVE_ENABLE_TOGGLE_STROBE = 8'h03;
  localparam logic [7:0] PAD_LEVEL_LATCH            = 8'h04;
  localparam logic [7:0] LEVEL_LATCH_SET_STROBE     = 8'h05;
  localparam logic [7:0] LEVEL_LATCH_CLEAR_STROBE   = 8'h06;
  localparam logic [7:0] LEVEL_LATCH_TOGGLE_STROBE  = 8'h07;
  localparam logic [7:0] SAMPLED_LEVEL              = 8'h08;
  localparam logic [7:0] PIN_EVENT_FLAGS            = 8'h09;
  localparam logic [7:0] PAD_CONFIG_PIN0            = 8'h10;
  localparam logic [7:0] ALIAS_BASE                 = 8'h20;
  localparam logic [7:0] ALIAS_DRIVE_ENABLE         = 8'h20;
  localparam logic [7:0] ALIAS_LEVEL_LATCH          = 8'h21;
  localparam logic [7:0] ALIAS_SAMPLED_LEVEL        = 8'h22;
  localparam logic [7:0] ALIAS_EVENT_FLAGS          = 8'h23;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         POLARITY_FLIP_BIT   = 7;
  localparam int         WEAK_HIGH_BIT       = 3;
  localparam int         SENSE_LSB           = 0;
  localparam logic [7:0] PAD_CONFIG_MASK     = 8'h8f;
  localparam logic [7:0] RESET_BYTE          = 8'h00;
  localparam logic [1:0] DEAD_TIME_CYCLES    = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SENSE_DUAL_EDGE = 3'h0,
    SENSE_RISING    = 3'h1,
    SENSE_FALLING   = 3'h2,
    SENSE_OFF       = 3'h4,
    SENSE_LOW_LEVEL = 3'h5
  } pgc_sense_e;

  typedef struct packed {
    logic       polarity_flip;
    logic [2:0] spare;
    logic       weak_high_resistor_on;
    logic [2:0] sense_select;
  } pgc_pad_config_s;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] level;
    logic [7:0] pull;
  } pgc_pad_out_s;

endpackage

//--- bench/pgc_pad_model.sv
// Board and pad model resolving the level each pin shows to the controller
`timescale 1ns/1ps
`default_nettype none
module pgc_pad_model (
  input  wire logic       i_sys_clk,    // Main clock, paces floating pattern
  input  wire logic [7:0] i_pad_out,    // Controller output level
  input  wire logic [7:0] i_pad_oe,     // Controller drive enable
  input  wire logic [7:0] i_pad_pullup, // Weak pull-up enable
  input  wire logic [7:0] i_ext_level,  // Board forced level
  input  wire logic [7:0] i_ext_en,     // Board drive enable
  output logic      [7:0] o_pad_level   // Resolved pad level
);
  // ****************************************
  // Pad resolution
  // ****************************************
  logic [7:0] float_pat;

  // Undriven pads without pull-up wander every cycle
  initial float_pat = 8'h55;
  always @(posedge i_sys_clk) float_pat <= ~float_pat;

  // Controller drive wins, then board, then pull-up, else floating
  assign o_pad_level = (i_pad_oe & i_pad_out)
                     | (~i_pad_oe & i_ext_en & i_ext_level)
                     | (~i_pad_oe & ~i_ext_en & (i_pad_pullup | float_pat));
endmodule
`default_nettype wire

//--- bench/pgc_pin_group_io_controller_chk.sv
// Port-level assertions for the pin group controller
`timescale 1ns/1ps
`default_nettype none
module pgc_pin_group_io_controller_chk #(
  parameter int       N_PINS     = 8,
  parameter bit [7:0] FULL_ASYNC = 8'h04
) (
  input wire logic              i_sys_clk,       // Clock
  input wire logic              i_reset_n,       // Reset, active low
  input wire logic              o_s_axi_bvalid,  // Write response valid
  input wire logic [1:0]        o_s_axi_bresp,   // Write response
  input wire logic              i_s_axi_bready,  // Write response ready
  input wire logic              i_s_axi_arvalid, // Read address valid
  input wire logic              o_s_axi_arready, // Read address ready
  input wire logic              o_s_axi_rvalid,  // Read data valid
  input wire logic              i_global_int_en, // Global interrupt enable
  input wire logic [N_PINS-1:0] o_pad_out,       // Pad level
  input wire logic [N_PINS-1:0] o_pad_oe,        // Pad drive enable
  input wire logic [N_PINS-1:0] o_pad_pullup,    // Pull-up enable
  input wire logic [N_PINS-1:0] o_pad_in_en,     // Input enable
  input wire logic              o_irq            // Interrupt request
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  chk_reset_safe: assert property ($past(!i_reset_n) |->
    o_pad_oe == '0 && o_pad_in_en == {N_PINS{1'b1}} && !o_irq) else $error("pads not safe after reset");
  chk_irq_gated: assert property (!i_global_int_en |-> !o_irq)
    else $error("irq high while globally disabled");
  chk_irq_holds: assert property ($past(o_irq) && $past(i_reset_n) && i_global_int_en
    && !$rose(o_s_axi_bvalid) |-> o_irq) else $error("irq dropped without a write");
  chk_dir_by_write: assert property ($changed(o_pad_oe) |-> $rose(o_s_axi_bvalid))
    else $error("direction changed without a write");
  chk_out_by_write: assert property ($changed(o_pad_out) |-> $rose(o_s_axi_bvalid))
    else $error("output level changed without a write");
  chk_pull_by_write: assert property ($changed(o_pad_pullup) |-> $rose(o_s_axi_bvalid))
    else $error("pull-up changed without a write");
  chk_sense_by_write: assert property ($changed(o_pad_in_en) |-> $rose(o_s_axi_bvalid))
    else $error("input enable changed without a write");
  chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  chk_resp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");

  cov_irq_rise: cover property ($rose(o_irq));
  cov_irq_fall: cover property ($fell(o_irq));
  cov_slverr: cover property ($rose(o_s_axi_bvalid) && o_s_axi_bresp == 2'h2);
endmodule

bind pgc_pin_group_io_controller pgc_pin_group_io_controller_chk #(.N_PINS(N_PINS), .FULL_ASYNC(FULL_ASYNC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_bresp(o_s_axi_bresp),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_global_int_en(i_global_int_en), .o_pad_out(o_pad_out),
  .o_pad_oe(o_pad_oe), .o_pad_pullup(o_pad_pullup), .o_pad_in_en(o_pad_in_en), .o_irq(o_irq));
`default_nettype wire

//--- bench/pin_group_io_controller_test.sv
// Register-level self-checking bench for the pin group controller
`timescale 1ns/1ps
`default_nettype none
module pin_group_io_controller_test;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [7:0] r; bit o;} pgc_step_s;
  logic        clk, rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready, gie, dbg, stop;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, irq, wake;
  logic [7:0]  aw_addr, ar_addr, ext_level, ext_en, pad_in, pad_out, pad_oe, pad_pull, in_en, ev_line;
  logic [31:0] w_data, r_data, rdat;
  logic [1:0]  b_resp, r_resp, resp;
  int          fails = 0;
  int          cmp_count = 0;
  pgc_step_s   steps [11] = '{'{8'h00, 8'h0f, 8'h0f, 8'h00, 0}, '{8'h01, 8'h30, 8'h3f, 8'h01, 0},
    '{8'h02, 8'h05, 8'h3a, 8'h02, 0}, '{8'h03, 8'h81, 8'hbb, 8'h03, 0}, '{8'h20, 8'h0f, 8'h0f, 8'h20, 0},
    '{8'h04, 8'h00, 8'h00, 8'h04, 1}, '{8'h05, 8'h11, 8'h11, 8'h04, 1}, '{8'h06, 8'h01, 8'h10, 8'h04, 1},
    '{8'h07, 8'h03, 8'h13, 8'h04, 1}, '{8'h08, 8'h10, 8'h03, 8'h04, 1}, '{8'h21, 8'h05, 8'h05, 8'h21, 1}};
  pgc_pkg::pgc_sense_e modes [5] = '{pgc_pkg::SENSE_DUAL_EDGE, pgc_pkg::SENSE_RISING,
    pgc_pkg::SENSE_FALLING, pgc_pkg::SENSE_LOW_LEVEL, pgc_pkg::SENSE_OFF};
  bit          fall_e [5] = '{1, 0, 1, 1, 0};
  bit          rise_e [5] = '{1, 1, 0, 1, 0};
  bit          wake_e [5] = '{1, 0, 0, 1, 0};

  // ****************************************
  // Design, pads and clock
  // ****************************************
  pgc_pin_group_io_controller dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_s_axi_awaddr(aw_addr),
    .i_s_axi_awvalid(aw_valid), .o_s_axi_awready(aw_ready), .i_s_axi_wdata(w_data), .i_s_axi_wstrb(4'h1),
    .i_s_axi_wvalid(w_valid), .o_s_axi_wready(w_ready), .o_s_axi_bresp(b_resp), .o_s_axi_bvalid(b_valid),
    .i_s_axi_bready(b_ready), .i_s_axi_araddr(ar_addr), .i_s_axi_arvalid(ar_valid), .o_s_axi_arready(ar_ready),
    .o_s_axi_rdata(r_data), .o_s_axi_rresp(r_resp), .o_s_axi_rvalid(r_valid), .i_s_axi_rready(r_ready),
    .i_pad_in(pad_in), .i_global_int_en(gie), .i_debug_mode(dbg), .i_clock_stopped(stop), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_pad_pullup(pad_pull), .o_pad_in_en(in_en), .o_pin_event_line(ev_line), .o_irq(irq),
    .o_wake(wake));
  pgc_pad_model u_pads (.i_sys_clk(clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pad_pullup(pad_pull),
    .i_ext_level(ext_level), .i_ext_en(ext_en), .o_pad_level(pad_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic final_report(input bit timed_out);
    if (timed_out) fails++;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok, done;
    done = 1'b0;
    @(posedge clk);
    aw_addr <= {a[5:0], 2'b00};
    w_data <= {24'h000000, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      aw_ok = aw_valid && (aw_ready === 1'b1);
      w_ok = w_valid && (w_ready === 1'b1);
      done = (b_valid === 1'b1);
      resp = b_resp;
      @(posedge clk);
      if (aw_ok) aw_valid <= 1'b0;
      if (w_ok) w_valid <= 1'b0;
      if (done) b_ready <= 1'b0;
    end
    if (!done) final_report(1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_ok, done;
    done = 1'b0;
    @(posedge clk);
    ar_addr <= {a[5:0], 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      ar_ok = ar_valid && (ar_ready === 1'b1);
      done = (r_valid === 1'b1);
      rdat = r_data;
      resp = r_resp;
      @(posedge clk);
      if (ar_ok) ar_valid <= 1'b0;
      if (done) r_ready <= 1'b0;
    end
    if (!done) final_report(1'b1);
  endtask
  task automatic rck(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk8($sformatf("register %h", a), e, rdat[7:0]);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready, dbg, stop} = '0;
    {aw_addr, ar_addr, ext_level, w_data} = '0;
    gie = 1'b1;
    ext_en = 8'hff;
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    chk8("pad_oe", 8'h00, pad_oe);
    chk8("in_en", 8'hff, in_en);
    rck(8'h10, 8'h00);
    rd(8'h0c);
    chk8("rresp", 8'h02, {6'h00, resp});
    wr(8'h0c, 8'hff);
    chk8("bresp", 8'h02, {6'h00, resp});
    $display("test reset done");
    foreach (steps[k]) begin
      wr(steps[k].a, steps[k].d);
      chk8("pad drive", steps[k].e, steps[k].o ? pad_out : pad_oe);
      rck(steps[k].r, steps[k].e);
    end
    tick(4);
    rck(8'h08, 8'h05);
    rck(8'h22, 8'h05);
    $display("test strobes done");
    wr(8'h16, 8'h08);
    chk8("pad_pull", 8'h40, pad_pull);
    ext_en <= 8'hbf;
    tick(6);
    wr(8'h09, 8'hff);
    wr(8'h14, 8'h80);
    tick(6);
    chk1("pad_out4", 1'b1, pad_out[4]);
    chk1("ev_line4", 1'b1, ev_line[4]);
    rck(8'h09, 8'h10);
    rck(8'h08, 8'h55);
    $display("test config done");
    dbg <= 1'b1;
    stop <= 1'b1;
    ext_level <= 8'h20;
    for (int k = 0; k < 5; k++) begin
      wr(8'h15, {5'h00, modes[k]});
      chk8("in_en", (modes[k] == pgc_pkg::SENSE_OFF) ? 8'hdf : 8'hff, in_en);
      tick(6);
      wr(8'h09, 8'hff);
      ext_level <= 8'h00;
      tick(1);
      chk1("wake", wake_e[k], wake);
      tick(7);
      rck(8'h23, {2'h0, fall_e[k], 5'h00});
      wr(8'h09, 8'hff);
      tick(6);
      ext_level <= 8'h20;
      tick(8);
      rck(8'h23, {2'h0, rise_e[k], 5'h00});
      wr(8'h09, 8'hff);
      tick(6);
      rck(8'h09, 8'h00);
    end
    ext_level <= 8'h00;
    tick(6);
    rd(8'h08);
    chk1("frozen sample", 1'b1, rdat[5]);
    wr(8'h15, 8'h00);
    tick(8);
    wr(8'h09, 8'hff);
    ext_level <= 8'h20;
    tick(8);
    chk1("irq", 1'b1, irq);
    wr(8'h09, 8'h00);
    chk1("irq", 1'b1, irq);
    gie <= 1'b0;
    tick(2);
    chk1("irq", 1'b0, irq);
    gie <= 1'b1;
    wr(8'h09, 8'h20);
    tick(2);
    chk1("irq", 1'b0, irq);
    $display("test sense done");
    final_report(1'b0);
  end
endmodule
`default_nettype wire
